// ===== core/psbp_pkg.sv
`default_nettype none
package psbp_pkg;

	// ----------------------------------------
	// Register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [7:0] IDX_HOST_DATA = 8'h08;
	localparam logic [7:0] IDX_CTL_PORT = 8'h09;
	localparam logic [7:0] IDX_FLAGS_ONE = 8'h0c;
	localparam logic [7:0] IDX_DATA_DIR = 8'h88;
	localparam logic [7:0] IDX_STATUS_DIR = 8'h89;
	localparam logic [7:0] IDX_ENABLES_ONE = 8'h8c;
	localparam logic [7:0] IDX_ANALOG_CFG = 8'h9f;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BIT_IN_FULL = 7;
	localparam int BIT_OUT_FULL = 6;
	localparam int BIT_IN_OVFL = 5;
	localparam int BIT_MODE = 4;
	localparam int BIT_PORT_IRQ = 7;
	localparam int BIT_ADFM = 7;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [2:0] RST_CTL_DIR = 3'h7;
	localparam logic [7:0] RST_DATA_DIR = 8'hff;
	localparam logic [7:0] RST_ENABLES = 8'h00;
	localparam logic [3:0] RST_PCFG = 4'h0;
	// Field value that makes the three control pins digital
	localparam logic [3:0] PCFG_CTL_DIGITAL = 4'h6;

	// ----------------------------------------
	// Instruction clock phases (four per cycle)
	// ----------------------------------------
	localparam int CLK_HZ = 20000000;
	localparam int PHASES = 4;
	localparam logic [1:0] PH_TWO = 2'h1;
	localparam logic [1:0] PH_FOUR = 2'h3;

	// ----------------------------------------
	// Transfer sequencer states
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WRITE = 3'b001,
		ST_READ = 3'b010,
		ST_WAIT2 = 3'b011,
		ST_WAIT4 = 3'b100
	} psbp_fsm_t;

endpackage
`default_nettype wire

// ===== core/psbp_port.sv
// ----------------------------------------
// ----------------------------------------
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module psbp_port #(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Data port pins
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic [7:0] data_oe_n,
	// Control pins: bit 0 read, bit 1 write, bit 2 select
	input wire logic [2:0] ctl_in,
	output logic [2:0] ctl_out,
	output logic [2:0] ctl_oe_n,
	// Masked port request
	output logic port_irq
);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	// The range check on paddr above bit 9 needs at least
	// one such bit, so a ten-bit bus cannot be served.
	// Wider buses up to 32 bits are fine: extra bits must read as zero.
	if (ADDR_W < 11 || ADDR_W > 32) begin : g_chk
		$error("ADDR_W must lie in 11..32");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [1:0] ph;
		psbp_pkg::psbp_fsm_t st;
		logic wr_kind;
		logic [2:0] s1;
		logic [2:0] s2;
		logic [7:0] d1;
		logic [7:0] d2;
		logic [7:0] out_latch;
		logic [7:0] in_latch;
		// Host side status: input full, output full, overflow
		logic in_full;
		logic out_full;
		logic in_ovfl;
		logic mode;
		logic [2:0] ctl_dir;
		logic [2:0] ctl_lat;
		logic [7:0] data_dir;
		logic irq_flag;
		logic [7:0] enables;
		logic adfm;
		logic [3:0] pcfg;
		logic [31:0] rdata;
	} psbp_state_t;

	localparam psbp_state_t RST = '{
		ph: 2'h0,
		st: psbp_pkg::ST_IDLE,
		wr_kind: 1'b0,
		s1: 3'h7,
		s2: 3'h7,
		d1: 8'h00,
		d2: 8'h00,
		out_latch: 8'h00,
		in_latch: 8'h00,
		in_full: 1'b0,
		out_full: 1'b0,
		in_ovfl: 1'b0,
		mode: 1'b0,
		ctl_dir: psbp_pkg::RST_CTL_DIR,
		ctl_lat: 3'h0,
		data_dir: psbp_pkg::RST_DATA_DIR,
		irq_flag: 1'b0,
		enables: psbp_pkg::RST_ENABLES,
		adfm: 1'b0,
		pcfg: psbp_pkg::RST_PCFG,
		rdata: 32'h0000_0000
	};

	psbp_state_t cur_ff;
	psbp_state_t nxt_st;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic [7:0] idx;
	logic hit;
	logic setup_ph;
	logic wr_acc;
	logic rd_acc;
	logic active;
	logic phase_two;
	logic phase_four;
	logic sel_wr;
	logic sel_rd;

	// Word index; upper address bits must be zero
	assign idx = paddr[9:2];
	always_comb begin
		hit = 1'b0;
		if (paddr[ADDR_W-1:10] == '0) begin
			case (idx)
				psbp_pkg::IDX_HOST_DATA,
				psbp_pkg::IDX_CTL_PORT,
				psbp_pkg::IDX_FLAGS_ONE,
				psbp_pkg::IDX_DATA_DIR,
				psbp_pkg::IDX_STATUS_DIR,
				psbp_pkg::IDX_ENABLES_ONE,
				psbp_pkg::IDX_ANALOG_CFG: hit = 1'b1;
				default: hit = 1'b0;
			endcase
		end
	end

	// Zero wait states: read data is caught in setup
	assign setup_ph = psel & ~penable;
	assign pready = psel & penable;
	assign pslverr = psel & penable & ~hit;
	assign wr_acc = pready & pwrite & hit & pstrb[0];
	assign rd_acc = pready & ~pwrite & hit;
	assign prdata = cur_ff.rdata;

	// Slave port usable only with inputs and digital pins
	assign active = cur_ff.mode
		& (cur_ff.ctl_dir == 3'h7)
		& (cur_ff.pcfg == psbp_pkg::PCFG_CTL_DIGITAL);

	// Phase strobes of the instruction clock
	assign phase_two = (cur_ff.ph == psbp_pkg::PH_TWO);
	assign phase_four = (cur_ff.ph == psbp_pkg::PH_FOUR);

	// Synchronised strobes, all active low
	assign sel_wr = ~cur_ff.s2[2] & ~cur_ff.s2[1];
	assign sel_rd = ~cur_ff.s2[2] & ~cur_ff.s2[0];

	// ----------------------------------------
	// Read data mux
	// ----------------------------------------
	function automatic logic [7:0] rd_mux(input psbp_state_t s, input logic [7:0] i,
		input logic [2:0] pins);
		logic [7:0] v;
		v = 8'h00;
		case (i)
			psbp_pkg::IDX_HOST_DATA: v = s.in_latch;
			psbp_pkg::IDX_CTL_PORT: v = {5'h00, pins};
			psbp_pkg::IDX_FLAGS_ONE: v = {s.irq_flag, 7'h00};
			psbp_pkg::IDX_DATA_DIR: v = s.data_dir;
			psbp_pkg::IDX_STATUS_DIR: v = {s.in_full, s.out_full, s.in_ovfl, s.mode, 1'b0,
				s.ctl_dir};
			psbp_pkg::IDX_ENABLES_ONE: v = s.enables;
			psbp_pkg::IDX_ANALOG_CFG: v = {s.adfm, 3'h0, s.pcfg};
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		nxt_st = cur_ff;
		nxt_st.ph = cur_ff.ph + 2'h1;

		// Two-stage sync of strobes and data bus.
		// Only the second stage is ever decoded: the first may
		// still be settling when the host moves a strobe at
		// an arbitrary point of our clock period.
		// The data bus goes through the same two stages so that
		// the byte lines up with the strobe release it belongs to.
		nxt_st.s1 = ctl_in;
		nxt_st.s2 = cur_ff.s1;
		nxt_st.d1 = data_in;
		nxt_st.d2 = cur_ff.d1;

		// Read data caught in the setup cycle
		if (setup_ph && !pwrite) begin
			nxt_st.rdata = {24'h000000, rd_mux(cur_ff, idx, ctl_in)};
		end

		// Outside slave mode the input latch follows the pins
		if (!active) begin
			nxt_st.in_latch = data_in;
		end

		// Firmware writes
		if (wr_acc) begin
			case (idx)
				psbp_pkg::IDX_HOST_DATA: begin
					nxt_st.out_latch = pwdata[7:0];
					nxt_st.out_full = 1'b1;
				end
				psbp_pkg::IDX_CTL_PORT: nxt_st.ctl_lat = pwdata[2:0];
				psbp_pkg::IDX_FLAGS_ONE: nxt_st.irq_flag = pwdata[psbp_pkg::BIT_PORT_IRQ];
				psbp_pkg::IDX_DATA_DIR: nxt_st.data_dir = pwdata[7:0];
				psbp_pkg::IDX_STATUS_DIR: begin
					// Overflow may only be cleared by firmware
					if (!pwdata[psbp_pkg::BIT_IN_OVFL]) begin
						nxt_st.in_ovfl = 1'b0;
					end
					nxt_st.mode = pwdata[psbp_pkg::BIT_MODE];
					nxt_st.ctl_dir = pwdata[2:0];
				end
				psbp_pkg::IDX_ENABLES_ONE: nxt_st.enables = pwdata[7:0];
				psbp_pkg::IDX_ANALOG_CFG: begin
					nxt_st.adfm = pwdata[psbp_pkg::BIT_ADFM];
					nxt_st.pcfg = pwdata[3:0];
				end
				default: nxt_st.ctl_lat = cur_ff.ctl_lat;
			endcase
		end

		// Firmware read of the data latch empties it
		if (rd_acc && idx == psbp_pkg::IDX_HOST_DATA) begin
			nxt_st.in_full = 1'b0;
		end

		// Host transfer sequencer; flag sets follow firmware accesses so they win.
		// A strobe release is followed by one wait for phase two
		// and one for phase four, so completion lands four to
		// seven clocks after the synchronised release.
		// Strobes seen while a completion is pending are dropped:
		// the host must leave a gap between transfers.
		// A cut frame (select rising early) still completes,
		// since any high level on either strobe ends it.
		case (cur_ff.st)
			psbp_pkg::ST_IDLE: begin
				if (active && sel_wr) begin
					nxt_st.st = psbp_pkg::ST_WRITE;
				end else if (active && sel_rd) begin
					nxt_st.st = psbp_pkg::ST_READ;
					nxt_st.out_full = 1'b0;
				end
			end
			psbp_pkg::ST_WRITE: begin
				if (!sel_wr) begin
					// Bus value sampled alongside the strobe release
					nxt_st.in_latch = cur_ff.d2;
					nxt_st.wr_kind = 1'b1;
					nxt_st.st = psbp_pkg::ST_WAIT2;
				end
			end
			psbp_pkg::ST_READ: begin
				// Held low so a firmware write mid-read cannot
				// claim a byte the host has already taken
				nxt_st.out_full = 1'b0;
				if (!sel_rd) begin
					nxt_st.wr_kind = 1'b0;
					nxt_st.st = psbp_pkg::ST_WAIT2;
				end
			end
			psbp_pkg::ST_WAIT2: begin
				if (phase_two) begin
					nxt_st.st = psbp_pkg::ST_WAIT4;
				end
			end
			psbp_pkg::ST_WAIT4: begin
				if (phase_four) begin
					nxt_st.st = psbp_pkg::ST_IDLE;
					nxt_st.irq_flag = 1'b1;
					if (cur_ff.wr_kind) begin
						nxt_st.in_full = 1'b1;
						// Unread byte was overwritten
						if (cur_ff.in_full) begin
							nxt_st.in_ovfl = 1'b1;
						end
					end
				end
			end
			default: nxt_st.st = psbp_pkg::ST_IDLE;
		endcase

		// Leaving slave mode drops both full flags, overflow and irq flag stay
		if (!active) begin
			nxt_st.st = psbp_pkg::ST_IDLE;
			nxt_st.in_full = 1'b0;
			nxt_st.out_full = 1'b0;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cur_ff <= RST;
		end else begin
			cur_ff <= nxt_st;
		end
	end

	// ----------------------------------------
	// Pin outputs
	// ----------------------------------------
	// Output latch drives whichever way the bus points
	assign data_out = cur_ff.out_latch;
	// Raw pins steer the bus so the read byte appears at once;
	// direction register has no say in slave mode.
	// Trade-off: the turn-around follows unsynchronised pins,
	// which is safe because it only steers the pad enable
	// and never feeds any state of this block.
	// A host that lowers read without select gets no drive.
	assign data_oe_n = active ? {8{ctl_in[2] | ctl_in[0]}}
		: cur_ff.data_dir;
	assign ctl_out = cur_ff.ctl_lat;
	assign ctl_oe_n = cur_ff.ctl_dir;

	// Masked request
	assign port_irq = cur_ff.irq_flag & cur_ff.enables[psbp_pkg::BIT_PORT_IRQ];

endmodule
`default_nettype wire

// ===== tb/psbp_port_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module psbp_port_sva (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins
	input wire logic [7:0] data_out,
	input wire logic [7:0] data_oe_n,
	input wire logic [2:0] ctl_in,
	input wire logic [2:0] ctl_out,
	input wire logic [2:0] ctl_oe_n,
	input wire logic port_irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// Zero wait states on every access
	apb_ready_a: assert property (pready == (psel && penable)) else $error("pready wrong");
	apb_err_a: assert property (pslverr |-> pready) else $error("pslverr outside access");
	// Read data only moves after a setup cycle
	rdata_hold_a: assert property (!$past(psel && !penable) |-> $stable(prdata))
		else $error("prdata moved");
	// Output latch, control latch and control direction only from firmware
	out_latch_a: assert property ($changed(data_out) |-> $past(psel && penable && pwrite))
		else $error("data_out moved");
	ctl_dir_a: assert property ($changed(ctl_oe_n) |-> $past(psel && penable && pwrite))
		else $error("ctl_oe_n moved");
	ctl_latch_a: assert property ($changed(ctl_out) |-> $past(psel && penable && pwrite))
		else $error("ctl_out moved");
	// Bus direction follows strobes or a register write only
	bus_dir_a: assert property ($changed(data_oe_n) |->
		$past(psel && penable && pwrite) || $changed(ctl_in)) else $error("oe moved");
	// Sticky flag: only firmware drops it
	irq_sticky_a: assert property ($fell(port_irq) |-> $past(psel && penable && pwrite))
		else $error("port_irq fell");
endmodule
bind psbp_port psbp_port_sva chk (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
	.pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.data_out(data_out), .data_oe_n(data_oe_n), .ctl_in(ctl_in), .ctl_out(ctl_out),
	.ctl_oe_n(ctl_oe_n), .port_irq(port_irq));
`default_nettype wire

// ===== tb/psbp_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// External processor model
// ----------------------------------------
module psbp_host (
	// Clock and bus
	input wire logic clk,
	input wire logic [7:0] bus,
	// Strobes: bit 0 read, 1 write, 2 select, active low
	output logic [2:0] ctl,
	output logic [7:0] drv
);
	// Idle: all strobes high, no clock on the link
	initial begin
		ctl = 3'h7;
		drv = 8'h00;
	end
	// Select and write low with data held past release
	task write_byte(input logic [7:0] v, input int hold);
		@(posedge clk);
		ctl <= 3'h1;
		drv <= v;
		repeat (hold) @(posedge clk);
		ctl <= 3'h7;
		repeat (3) @(posedge clk);
		drv <= ~v; // Released: stale value inverted
		repeat (10) @(posedge clk);
	endtask
	// Select and read low; byte taken before release
	task read_byte(input int hold, output logic [7:0] v);
		@(posedge clk);
		ctl <= 3'h2;
		repeat (hold) @(posedge clk);
		v = bus;
		ctl <= 3'h7;
		repeat (10) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// ===== tb/parallel_slave_byte_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Bench
// ----------------------------------------
module parallel_slave_byte_port_bench;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, port_irq, err;
	logic [7:0] data_out, data_oe_n, drv, bus, b;
	logic [2:0] ctl_in, ctl_out, ctl_oe_n;
	int fails = 0;
	int comparisons = 0;
	int cycles = 0;
	always #25 clk = ~clk;
	// Wire level: device drives while its enable is low
	assign bus = data_oe_n[0] ? drv : data_out;
	psbp_port dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .data_in(bus), .data_out(data_out), .data_oe_n(data_oe_n),
		.ctl_in(ctl_in), .ctl_out(ctl_out), .ctl_oe_n(ctl_oe_n), .port_irq(port_irq));
	psbp_host host (.clk(clk), .bus(bus), .ctl(ctl_in), .drv(drv));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One APB transfer, waits on pready
	task apb(input logic w, input logic [7:0] idx, input logic [31:0] wd,
		output logic [31:0] rd);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task wr(input logic [7:0] idx, input logic [7:0] v);
		logic [31:0] r;
		apb(1'b1, idx, {24'h0, v}, r);
	endtask
	task rchk(input logic [7:0] idx, input logic [7:0] exp);
		logic [31:0] r;
		apb(1'b0, idx, 32'h0, r);
		chk(r, {24'h0, exp});
	endtask
	// Reset values, refusal, slave set-up
	task t_regs;
		rchk(psbp_pkg::IDX_STATUS_DIR, 8'h07);
		rchk(psbp_pkg::IDX_FLAGS_ONE, 8'h00);
		rchk(psbp_pkg::IDX_ENABLES_ONE, 8'h00);
		rchk(8'h01, 8'h00);
		chk(err, 1'b1);
		wr(psbp_pkg::IDX_ANALOG_CFG, {4'h0, psbp_pkg::PCFG_CTL_DIGITAL});
		wr(psbp_pkg::IDX_STATUS_DIR, 8'h17);
		wr(psbp_pkg::IDX_ENABLES_ONE, 8'h80);
		wr(psbp_pkg::IDX_HOST_DATA, 8'h5a);
		rchk(psbp_pkg::IDX_STATUS_DIR, 8'h57);
	endtask
	// Two host writes, second onto unread byte
	task t_write;
		host.write_byte(8'ha5, 4);
		chk(port_irq, 1'b1);
		rchk(psbp_pkg::IDX_STATUS_DIR, 8'hd7);
		host.write_byte(8'h3c, 1);
		rchk(psbp_pkg::IDX_STATUS_DIR, 8'hf7);
		rchk(psbp_pkg::IDX_HOST_DATA, 8'h3c);
		rchk(psbp_pkg::IDX_STATUS_DIR, 8'h77);
		wr(psbp_pkg::IDX_FLAGS_ONE, 8'h00);
		chk(port_irq, 1'b0);
	endtask
	// Host read, then masked flag
	task t_read;
		host.read_byte(4, b);
		chk(b, 8'h5a);
		rchk(psbp_pkg::IDX_STATUS_DIR, 8'h37);
		chk(port_irq, 1'b1);
		wr(psbp_pkg::IDX_ENABLES_ONE, 8'h00);
		chk(port_irq, 1'b0);
		rchk(psbp_pkg::IDX_FLAGS_ONE, 8'h80);
	endtask
	// Leaving slave mode drops output full flag, keeps overflow
	task t_exit;
		wr(psbp_pkg::IDX_HOST_DATA, 8'h11);
		wr(psbp_pkg::IDX_STATUS_DIR, 8'h27);
		rchk(psbp_pkg::IDX_STATUS_DIR, 8'h27);
		wr(psbp_pkg::IDX_STATUS_DIR, 8'h07);
		rchk(psbp_pkg::IDX_STATUS_DIR, 8'h07);
	endtask
	task report_and_stop;
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Hang guard, far above the roughly 120 cycles needed
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fails++;
			report_and_stop;
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		t_regs;
		t_write;
		t_read;
		t_exit;
		report_and_stop;
	end
endmodule
`default_nettype wire
